// ===== logic/wdat_top.sv
`timescale 1ns/1ps
module wdat_top #(
  parameter int DET_EXP = wdat_pkg::DET_EXP_MIN
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire wdat_pkg::wdat_fetch_type fetch,
  input wire logic lowSpeedMode,
  output logic fetchTrapIrq,
  output logic overflowIrq,
  output logic hwReset,
  output logic hfOscRestart,
  output logic irq
);
  import wdat_pkg::*;

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  wdat_state_type state_q, state_d;
  wdat_cfg_type cfg_q, cfg_d;
  logic ramTrapActive_q, ramTrapActive_d;
  logic wdActive_q, wdActive_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic divTap_q, divTap_d;
  logic [1:0] binCnt_q, binCnt_d;
  logic [4:0] rstCnt_q, rstCnt_d;
  logic [ST_W-1:0] status_q, status_d;
  logic [ST_W-1:0] mask_q, mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic trapIrq_q, trapIrq_d;
  logic ovfIrq_q, ovfIrq_d;
  logic oscRestart_q, oscRestart_d;

  localparam logic [4:0] RST_LAST = 5'(RESET_CYCLES - 1);

  logic setup, wrEn, decHit;
  logic cfgWr, codeWr, statusWr, maskWr;
  logic [7:0] code;
  logic tapBit, tick, overflow;
  logic inSfr, inRam, inDbr, trapHit;
  logic rstReq, trapCommit;
  logic [ST_W-1:0] events;
  int tapIdx;

  // ----------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------
  // No wait states; a frozen clock enable stalls the access
  assign pready = clkEn;
  assign setup = psel && !penable;
  assign wrEn = psel && penable && pwrite && pready;
  assign decHit = paddr[11:2] == IDX_CONFIG || paddr[11:2] == IDX_CODE ||
                  paddr[11:2] == IDX_STATUS || paddr[11:2] == IDX_MASK ||
                  paddr[11:2] == IDX_STATE;
  assign pslverr = psel && penable && !decHit;
  assign cfgWr = wrEn && paddr[11:2] == IDX_CONFIG;
  assign codeWr = wrEn && paddr[11:2] == IDX_CODE;
  assign statusWr = wrEn && paddr[11:2] == IDX_STATUS;
  assign maskWr = wrEn && paddr[11:2] == IDX_MASK;
  assign code = pwdata[7:0];
  assign trapCommit = codeWr && code == CODE_TRAP;
  assign prdata = rdata_q;

  // ----------------------------------------------------------
  // Watchdog divider and binary counter
  // ----------------------------------------------------------
  // Overflow after four falling edges of the tap: 2^(DET_EXP + 6 - 2*detectTime) cycles
  always_comb begin
    tapIdx = DET_EXP - 3 + 2 * (3 - int'(cfg_q.detectTime));
    if (tapIdx > DIV_W - 1) begin
      tapIdx = DIV_W - 1;
    end
    if (tapIdx < 0) begin
      tapIdx = 0;
    end
  end
  assign tapBit = div_q[tapIdx];
  assign tick = wdActive_q && divTap_q && !tapBit;
  assign overflow = tick && binCnt_q == 2'd3;

  // ----------------------------------------------------------
  // Address trap check
  // ----------------------------------------------------------
  assign inSfr = fetch.addr >= SFR_LO && fetch.addr <= SFR_HI;
  assign inRam = fetch.addr >= RAM_LO && fetch.addr <= RAM_HI;
  assign inDbr = fetch.addr >= DBR_LO && fetch.addr <= DBR_HI;
  assign trapHit = state_q == ST_RUN && fetch.valid && fetch.opcode &&
                   (inSfr || inDbr ||
                    (inRam && ramTrapActive_q));

  // Reset wins when both sources fire together
  assign rstReq = state_q == ST_RUN &&
                  ((overflow && cfg_q.overflowActionSelect) ||
                   (trapHit && cfg_q.trapActionSelect));
  assign events[ST_OVF] = state_q == ST_RUN && overflow;
  assign events[ST_TRAP] = trapHit;
  assign events[ST_RST] = rstReq;

  // ----------------------------------------------------------
  // Next state
  // ----------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cfg_d = cfg_q;
    ramTrapActive_d = ramTrapActive_q;
    wdActive_d = wdActive_q;
    div_d = div_q;
    divTap_d = divTap_q;
    binCnt_d = binCnt_q;
    rstCnt_d = rstCnt_q;
    mask_d = mask_q;
    rdata_d = rdata_q;
    trapIrq_d = 1'b0;
    ovfIrq_d = 1'b0;
    oscRestart_d = 1'b0;
    // Set wins over a write-one clear in the same cycle
    status_d = status_q;
    if (statusWr) begin
      status_d = status_q & ~pwdata[ST_W-1:0];
    end
    status_d = status_d | events;
    if (maskWr) begin
      mask_d = pwdata[ST_W-1:0];
    end
    if (setup) begin
      unique case (paddr[11:2])
        IDX_STATUS: rdata_d = {29'h0, status_q};
        IDX_MASK: rdata_d = {29'h0, mask_q};
        IDX_STATE: rdata_d = {26'h0, ramTrapActive_q, wdActive_q, binCnt_q, 1'b0, state_q == ST_RESET};
        default: rdata_d = 32'h0;
      endcase
    end
    unique case (state_q)
      ST_RUN: begin
        if (wdActive_q) begin
          div_d = div_q + 1'b1;
          divTap_d = tapBit;
          if (tick) begin
            binCnt_d = binCnt_q + 1'b1;
          end
        end else begin
          // Disabled: binary counter held clear
          binCnt_d = 2'd0;
        end
        if (cfgWr) begin
          cfg_d = wdat_cfg_type'(pwdata[7:0]);
          cfg_d.spare = 2'b00;
          // Overflow action bit can be cleared by a write; only a reset sets it again
          cfg_d.overflowActionSelect = cfg_q.overflowActionSelect & pwdata[0];
          if (pwdata[3]) begin
            wdActive_d = 1'b1;
          end
        end
        if (codeWr) begin
          unique case (code)
            CODE_CLEAR: binCnt_d = 2'd0;
            CODE_DISABLE: begin
              if (!cfg_q.counterEnableBit) begin
                wdActive_d = 1'b0;
                binCnt_d = 2'd0;
              end
            end
            CODE_TRAP: ramTrapActive_d = cfg_q.ramTrapSelect;
            default: ;
          endcase
        end
        if (rstReq) begin
          state_d = ST_RESET;
          rstCnt_d = 5'd0;
          oscRestart_d = lowSpeedMode;
        end else begin
          trapIrq_d = trapHit && !cfg_q.trapActionSelect;
          ovfIrq_d = overflow && !cfg_q.overflowActionSelect;
        end
      end
      ST_RESET: begin
        // Counted on the fast clock, so low-speed mode changes nothing
        rstCnt_d = rstCnt_q + 1'b1;
        if (rstCnt_q == RST_LAST) begin
          state_d = ST_RUN;
          cfg_d = wdat_cfg_type'(CFG_RESET);
          ramTrapActive_d = 1'b0;
          wdActive_d = 1'b1;
          div_d = '0;
          divTap_d = 1'b0;
          binCnt_d = 2'd0;
          mask_d = '0;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_RUN;
      cfg_q <= wdat_cfg_type'(CFG_RESET);
      ramTrapActive_q <= 1'b0;
      wdActive_q <= 1'b1;
      div_q <= '0;
      divTap_q <= 1'b0;
      binCnt_q <= 2'd0;
      rstCnt_q <= 5'd0;
      status_q <= '0;
      mask_q <= '0;
      rdata_q <= 32'h0;
      trapIrq_q <= 1'b0;
      ovfIrq_q <= 1'b0;
      oscRestart_q <= 1'b0;
    end else if (clkEn) begin
      state_q <= state_d;
      cfg_q <= cfg_d;
      ramTrapActive_q <= ramTrapActive_d;
      wdActive_q <= wdActive_d;
      div_q <= div_d;
      divTap_q <= divTap_d;
      binCnt_q <= binCnt_d;
      rstCnt_q <= rstCnt_d;
      status_q <= status_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      trapIrq_q <= trapIrq_d;
      ovfIrq_q <= ovfIrq_d;
      oscRestart_q <= oscRestart_d;
    end
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  // Nesting of the non-maskable requests is left to the core
  assign fetchTrapIrq = trapIrq_q;
  assign overflowIrq = ovfIrq_q;
  assign hwReset = state_q == ST_RESET;
  assign hfOscRestart = oscRestart_q;
  assign irq = |(status_q & mask_q);

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !clkEn);

  sequence s_cfg_ram_write;
    cfgWr && state_q == ST_RUN;
  endsequence
  sequence s_trap_commit;
    trapCommit && state_q == ST_RUN;
  endsequence

  a_ovf_to_reset: assert property (overflow && cfg_q.overflowActionSelect && state_q == ST_RUN |=> hwReset)
    else $error("overflow with reset select gave no reset");
  a_reset_start: assert property ($rose(hwReset) |-> rstCnt_q == 5'd0 && status_q[ST_RST])
    else $error("reset pulse started badly");
  a_reset_length: assert property (hwReset && rstCnt_q == RST_LAST |=> !hwReset)
    else $error("reset pulse too long");
  a_reset_bound: assert property (hwReset |-> rstCnt_q <= RST_LAST)
    else $error("reset counter beyond limit");
  a_slow_restart: assert property (rstReq && lowSpeedMode |=> hfOscRestart && hwReset)
    else $error("no oscillator restart on slow reset");
  a_ram_commit: assert property (s_cfg_ram_write ##[1:8] s_trap_commit
                                 |=> ramTrapActive_q == $past(cfg_q.ramTrapSelect))
    else $error("ram trap selection not committed");
  a_ram_hold: assert property (!trapCommit && state_q == ST_RUN |=> $stable(ramTrapActive_q) || hwReset)
    else $error("ram trap selection changed without commit");
  a_ram_normal: assert property (fetch.valid && inRam && !inSfr && !inDbr && !ramTrapActive_q |-> !trapHit)
    else $error("ram fetch trapped while not selected");
  a_area_trap: assert property (state_q == ST_RUN && fetch.valid && fetch.opcode && (inSfr || inDbr)
                                |-> trapHit)
    else $error("register area fetch did not trap");
  a_trap_irq: assert property (trapHit && !rstReq |=> fetchTrapIrq && !hwReset)
    else $error("trap interrupt missing");
  a_trap_reset: assert property (trapHit && cfg_q.trapActionSelect |=> hwReset && !fetchTrapIrq)
    else $error("trap reset missing");
  a_data_ignored: assert property (fetch.valid && !fetch.opcode |-> !trapHit)
    else $error("data access trapped");
  a_ovf_irq: assert property (overflow && state_q == ST_RUN && !rstReq |=> overflowIrq)
    else $error("watchdog interrupt missing");
  a_disable_guard: assert property (codeWr && code == CODE_DISABLE && cfg_q.counterEnableBit
                                    && state_q == ST_RUN |=> wdActive_q)
    else $error("disable accepted while enable bit set");
  // A same-cycle status clear loses to the event, so only a mask write can hide it
  a_irq_level: assert property (trapHit && mask_q[ST_TRAP] && !maskWr |=> irq)
    else $error("unmasked trap gave no interrupt level");

endmodule

// ===== pkg/wdat_pkg.sv
package wdat_pkg;

  // ----------------------------------------------------------
  // Register map: word index, byte address is four times it
  // ----------------------------------------------------------
  localparam logic [9:0] IDX_CONFIG = 10'h034;
  localparam logic [9:0] IDX_CODE = 10'h035;
  localparam logic [9:0] IDX_STATUS = 10'h038;
  localparam logic [9:0] IDX_MASK = 10'h039;
  localparam logic [9:0] IDX_STATE = 10'h03a;

  localparam logic [7:0] CODE_CLEAR = 8'h4e;
  localparam logic [7:0] CODE_DISABLE = 8'hb1;
  localparam logic [7:0] CODE_TRAP = 8'hd2;

  // Status and mask bit positions
  localparam int ST_OVF = 0;
  localparam int ST_TRAP = 1;
  localparam int ST_RST = 2;
  localparam int ST_W = 3;

  // ----------------------------------------------------------
  // Configuration layout and reset value
  // ----------------------------------------------------------
  typedef struct packed {
    logic [1:0] spare;
    logic ramTrapSelect;
    logic trapActionSelect;
    logic counterEnableBit;
    logic [1:0] detectTime;
    logic overflowActionSelect;
  } wdat_cfg_type;

  localparam logic [7:0] CFG_RESET = 8'h39;

  // ----------------------------------------------------------
  // Instruction fetch from the core
  // ----------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic opcode;
    logic [15:0] addr;
  } wdat_fetch_type;

  localparam logic [15:0] SFR_LO = 16'h0000;
  localparam logic [15:0] SFR_HI = 16'h003f;
  localparam logic [15:0] RAM_LO = 16'h0040;
  localparam logic [15:0] RAM_HI = 16'h023f;
  localparam logic [15:0] DBR_LO = 16'h0f80;
  localparam logic [15:0] DBR_HI = 16'h0fff;

  // ----------------------------------------------------------
  // Timing
  // ----------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int FC_HZ = 10_000_000;
  localparam int RESET_FC_PERIODS = 24;
  // Longest time: round down
  localparam int RESET_CYCLES = (RESET_FC_PERIODS * CLK_HZ) / FC_HZ;
  localparam int DET_EXP_MIN = 19;
  localparam int DIV_W = 24;

  typedef enum logic {ST_RUN, ST_RESET} wdat_state_type;

endpackage

// ===== testbench/wdat_core_model.sv
`timescale 1ns/1ps
// Core side: issues instruction fetches and takes the NMI and reset requests
module wdat_core_model
  import wdat_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic fetchTrapIrq,
  input wire logic overflowIrq,
  input wire logic hwReset,
  output wdat_pkg::wdat_fetch_type fetch
);
  int trapNmi;
  int ovfNmi;
  int nestDepth;
  logic globalIrqEnable;
  logic stackReady;

  initial begin
    fetch = '0;
    trapNmi = 0;
    ovfNmi = 0;
    nestDepth = 0;
    globalIrqEnable = 1'b0;
    stackReady = 1'b1;
  end

  // ----------------------------------------------------------
  // Request intake
  // ----------------------------------------------------------
  // Global enable stays low on purpose: these requests must still be taken
  always @(posedge clk) begin
    if (sys_rst || hwReset) begin
      nestDepth <= 0;
    end else if (stackReady) begin
      trapNmi <= trapNmi + int'(fetchTrapIrq);
      ovfNmi <= ovfNmi + int'(overflowIrq);
      nestDepth <= nestDepth + int'(fetchTrapIrq) + int'(overflowIrq);
    end
  end

  // One fetch; the bus is then released with the complemented address, not the old one
  task automatic fetchOnce(input logic [15:0] a, input logic op);
    @(posedge clk);
    fetch <= {1'b1, op, a};
    @(posedge clk);
    fetch <= {1'b0, ~op, ~a};
  endtask
endmodule

// ===== testbench/wdat_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  begin \
    n_compared++; \
    if ((gt) !== (ex)) begin \
      $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); \
      n_errors++; \
    end \
  end
module wdat_top_tb;
  import wdat_pkg::*;
  typedef struct packed {
    logic [15:0] addr;
    logic op;
    logic trap;
  } wdat_row_type;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic lowSpeedMode = 1'b0;
  logic fetchTrapIrq, overflowIrq, hwReset, hfOscRestart, irq;
  wdat_fetch_type fetch;
  int n_errors = 0;
  int n_compared = 0;
  int n;
  int k;
  logic [31:0] rd;
  logic err;
  localparam logic [11:0] A_CFG = {IDX_CONFIG, 2'b00};
  localparam logic [11:0] A_CODE = {IDX_CODE, 2'b00};
  localparam logic [11:0] A_ST = {IDX_STATUS, 2'b00};
  localparam logic [11:0] A_MASK = {IDX_MASK, 2'b00};
  localparam logic [11:0] A_STATE = {IDX_STATE, 2'b00};
  wdat_row_type rows [8] = '{
    {SFR_LO, 1'b1, 1'b1}, {SFR_HI, 1'b1, 1'b1}, {RAM_LO, 1'b1, 1'b0}, {RAM_HI, 1'b1, 1'b0},
    {DBR_LO, 1'b1, 1'b1}, {DBR_HI, 1'b1, 1'b1}, {16'h1000, 1'b1, 1'b0}, {SFR_LO, 1'b0, 1'b0}};

  initial begin
    forever #50 clk = ~clk;
  end

  wdat_top #(.DET_EXP(4)) wdat_top_i (.clk(clk), .sys_rst(sysRst), .clkEn(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fetch(fetch), .lowSpeedMode(lowSpeedMode), .fetchTrapIrq(fetchTrapIrq),
    .overflowIrq(overflowIrq), .hwReset(hwReset), .hfOscRestart(hfOscRestart), .irq(irq));
  wdat_core_model wdat_core_model_i (.clk(clk), .sys_rst(sysRst), .fetchTrapIrq(fetchTrapIrq),
    .overflowIrq(overflowIrq), .hwReset(hwReset), .fetch(fetch));

  // ----------------------------------------------------------
  // Bus and fetch helpers
  // ----------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic trapFetch(input logic [15:0] a, input logic exp);
    wdat_core_model_i.fetchOnce(a, 1'b1);
    #1;
    `CHK("trap pulse", exp, fetchTrapIrq)
  endtask

  task automatic resetWidth(input logic osc);
    `CHK("osc restart", osc, hfOscRestart)
    n = 0;
    while (hwReset === 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("reset width", RESET_CYCLES, n)
  endtask

  task automatic summarize;
    $display("Errors %0d of %0d checks", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    sysRst <= 1'b0;
    apb(1'b0, A_STATE, 32'h0);
    `CHK("state after reset", 32'h10, rd & 32'h31)
    apb(1'b1, A_CODE, {24'h0, CODE_DISABLE});
    apb(1'b0, A_STATE, 32'h0);
    `CHK("disable refused", 32'h10, rd & 32'h10)
    apb(1'b1, A_CFG, 32'h00);
    apb(1'b1, A_CODE, {24'h0, CODE_CLEAR});
    apb(1'b1, A_CODE, {24'h0, CODE_DISABLE});
    apb(1'b0, A_STATE, 32'h0);
    `CHK("disabled", 32'h0, rd & 32'h10)
    apb(1'b0, 12'hffc, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    for (k = 0; k < 8; k++) begin
      wdat_core_model_i.fetchOnce(rows[k].addr, rows[k].op);
      #1;
      `CHK("row trap", rows[k].trap, fetchTrapIrq)
    end
    trapFetch(SFR_LO, 1'b1);
    trapFetch(DBR_LO, 1'b1);
    // The core counts the last pulse at the edge that ends it
    @(posedge clk);
    #1;
    `CHK("nmi count", 4 + 2, wdat_core_model_i.trapNmi)
    `CHK("nest depth", 4 + 2, wdat_core_model_i.nestDepth)
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, A_MASK, 32'h2);
    #1;
    `CHK("irq set", 1'b1, irq)
    apb(1'b1, A_ST, 32'h2);
    #1;
    `CHK("irq cleared", 1'b0, irq)
    apb(1'b1, A_CFG, 32'h20);
    trapFetch(16'h0100, 1'b0);
    apb(1'b1, A_CODE, {24'h0, CODE_TRAP});
    trapFetch(16'h0100, 1'b1);
    apb(1'b1, A_CFG, 32'h00);
    apb(1'b1, A_CODE, 32'h55);
    trapFetch(RAM_LO, 1'b1);
    apb(1'b1, A_CODE, {24'h0, CODE_TRAP});
    trapFetch(RAM_LO, 1'b0);
    apb(1'b1, A_CFG, 32'h10);
    lowSpeedMode <= 1'b1;
    trapFetch(SFR_LO, 1'b0);
    `CHK("trap reset", 1'b1, hwReset)
    resetWidth(1'b1);
    lowSpeedMode <= 1'b0;
    apb(1'b0, A_ST, 32'h0);
    `CHK("reset cause", 32'h4, rd & 32'h4)
    n = 0;
    while (hwReset !== 1'b1 && n < 1300) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("watchdog reset", 1'b1, hwReset)
    `CHK("no ovf nmi", 0, wdat_core_model_i.ovfNmi)
    resetWidth(1'b0);
    apb(1'b1, A_CFG, 32'h0e);
    for (k = 0; k < 12; k++) begin
      repeat (4) @(posedge clk);
      apb(1'b1, A_CODE, {24'h0, CODE_CLEAR});
    end
    `CHK("cleared in time", 0, wdat_core_model_i.ovfNmi)
    n = 0;
    while (wdat_core_model_i.ovfNmi == 0 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("ovf nmi", 1, wdat_core_model_i.ovfNmi)
    `CHK("no reset", 1'b0, hwReset)
    summarize();
  end
endmodule
